// File: tdp_pkg.sv
// =====================================================
// trace and serial debug pin package
package tdp_pkg;

	// =====================================================
	// configuration word fields
	localparam int CFG_W = 32;
	localparam int CFG_TRACE_DISABLE_BIT = 17;
	localparam int CFG_BRANCH_BYTES_LSB = 8;
	localparam logic [1:0] BRANCH_BYTES_OFF = 2'h0;

	// =====================================================
	// processor status codes
	localparam logic [3:0] PST_CONTINUE = 4'h0;
	localparam logic [3:0] PST_BEGIN = 4'h1;
	localparam logic [3:0] PST_USER = 4'h3;
	localparam logic [3:0] PST_PULSE_WDATA = 4'h4;
	localparam logic [3:0] PST_BRANCH = 4'h5;
	localparam logic [3:0] PST_RETURN_EXC = 4'h7;
	localparam logic [3:0] PST_MARK_BASE = 4'h8;
	localparam logic [3:0] PST_EXCEPTION = 4'hC;
	localparam logic [3:0] PST_EMU_EXC = 4'hD;
	localparam logic [3:0] PST_STOPPED = 4'hE;
	localparam logic [3:0] PST_HALTED = 4'hF;

	// =====================================================
	// widths, depths and reset values
	localparam int TRACE_W = 32;
	localparam int TRACE_DEPTH = 2;
	localparam int SERIAL_W = 17;
	localparam int SYNC_STAGES = 2;
	localparam logic [3:0] NIBBLE_RESET = 4'h0;

	// =====================================================
	// core side trace request
	typedef struct packed {
		logic [3:0] code;
		logic branch_variant;
		logic wdata;
		logic [1:0] wdata_bytes_m1;
		logic [TRACE_W-1:0] value;
	} tdp_core_s;

	// captured entry
	typedef struct packed {
		logic [1:0] bytes_m1;
		logic [TRACE_W-1:0] value;
	} tdp_entry_s;

	// drain states
	typedef enum logic [1:0] {
		DR_IDLE = 2'b00,
		DR_MARK = 2'b01,
		DR_DATA = 2'b10
	} tdp_drain_e;

	// halt states
	typedef enum logic [1:0] {
		HT_RUN = 2'b00,
		HT_PEND = 2'b01,
		HT_HALT = 2'b10
	} tdp_halt_e;

endpackage

// File: tdp_fifo.sv
`timescale 1ns/1ps
// small trace store, head word comes out of a register
module tdp_fifo #(
	parameter int WIDTH = 34,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic push,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic pop,
	output logic [WIDTH-1:0] rdata,
	output logic empty,
	output logic full
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	initial begin
		if (DEPTH != (1 << AW) || DEPTH < 2)
			$error("tdp_fifo depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [AW:0] count;
	logic [AW-1:0] next_rptr;
	logic do_push;
	logic do_pop;

	assign do_push = push && !full;
	assign do_pop = pop && !empty;
	assign next_rptr = do_pop ? rptr + AW'(1) : rptr;
	assign empty = (count == '0);
	assign full = (count == (AW+1)'(DEPTH));

	// storage write
	always_ff @(posedge clk) begin
		if (do_push)
			mem[wptr] <= wdata;
	end

	// pointers and fill count
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end else begin
			if (do_push)
				wptr <= wptr + AW'(1);
			rptr <= next_rptr;
			count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	// registered head with write forwarding
	always_ff @(posedge clk) begin
		if (!rst_b)
			rdata <= '0;
		else if (do_push && wptr == next_rptr)
			rdata <= wdata;
		else
			rdata <= mem[next_rptr];
	end
endmodule

// File: tdp_top.sv
`timescale 1ns/1ps
module tdp_top #(
	parameter int SER_W = tdp_pkg::SERIAL_W,
	parameter int DEPTH = tdp_pkg::TRACE_DEPTH
) (
	input wire logic CLK,
	input wire logic RST_B,
	// pins
	input wire logic BREAKPOINT_REQUEST_N,
	input wire logic DEV_SERIAL_CLOCK,
	input wire logic DEV_SERIAL_IN,
	output logic DEV_SERIAL_OUT,
	output logic [3:0] PROCESSOR_STATUS_CODE,
	output logic [3:0] DEBUG_DATA_NIBBLE,
	output logic STATUS_SAMPLE_CLOCK,
	// configuration and breakpoint unit
	input wire logic [tdp_pkg::CFG_W-1:0] DEBUG_CONFIG_STATUS,
	input wire logic [3:0] BREAKPOINT_STATUS,
	// core side
	input wire tdp_pkg::tdp_core_s CORE_TRACE,
	input wire logic CORE_INSTR_DONE,
	input wire logic CORE_RESUME,
	output logic CORE_STALL,
	output logic CORE_HALT,
	// debug module serial side
	input wire logic [SER_W-1:0] SER_TX_WORD,
	output logic SER_TX_LOAD,
	output logic [SER_W-1:0] SER_RX_WORD,
	output logic SER_RX_VALID
);
	localparam int EW = $bits(tdp_pkg::tdp_entry_s);
	localparam int CW = $clog2(SER_W + 1);

	initial begin
		if (SER_W < 2)
			$error("tdp_top serial word must be at least 2 bits");
		if (DEPTH != 2)
			$error("tdp_top trace store depth must be 2");
	end

	// =====================================================
	// pin synchronizers
	logic [2:0] pin_raw;
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic sclk_prev;
	logic breakpoint_request_n_req;
	logic sclk_rise;
	logic sdi;

	assign pin_raw = {DEV_SERIAL_IN, DEV_SERIAL_CLOCK, BREAKPOINT_REQUEST_N};

	// two flops per pin, first stage feeds only the second
	generate
		for (genvar i = 0; i < 3; i++) begin : g_sync
			always_ff @(posedge CLK) begin
				if (!RST_B) begin
					sync_a[i] <= 1'b1;
					sync_b[i] <= 1'b1;
				end else begin
					sync_a[i] <= pin_raw[i];
					sync_b[i] <= sync_a[i];
				end
			end
		end
	endgenerate

	// serial clock edge history
	always_ff @(posedge CLK) begin
		if (!RST_B)
			sclk_prev <= 1'b1;
		else
			sclk_prev <= sync_b[1];
	end

	assign breakpoint_request_n_req = !sync_b[0];
	assign sclk_rise = sync_b[1] && !sclk_prev;
	assign sdi = sync_b[2];

	// =====================================================
	// serial port shifter
	logic [SER_W-1:0] rx_shift;
	logic [SER_W-1:0] tx_shift;
	logic [CW-1:0] bit_cnt;
	logic last_bit;

	assign last_bit = (bit_cnt == CW'(SER_W - 1));
	assign SER_TX_LOAD = sclk_rise && last_bit;

	// bit counter per synced edge
	always_ff @(posedge CLK) begin
		if (!RST_B)
			bit_cnt <= '0;
		else if (sclk_rise)
			bit_cnt <= last_bit ? '0 : bit_cnt + CW'(1);
	end

	// receive shift, msb first
	always_ff @(posedge CLK) begin
		if (!RST_B)
			rx_shift <= '0;
		else if (sclk_rise)
			rx_shift <= {rx_shift[SER_W-2:0], sdi};
	end

	// received word handoff
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			SER_RX_WORD <= '0;
			SER_RX_VALID <= 1'b0;
		end else begin
			SER_RX_VALID <= sclk_rise && last_bit;
			if (sclk_rise && last_bit)
				SER_RX_WORD <= {rx_shift[SER_W-2:0], sdi};
		end
	end

	// response shift, reloaded at word end
	always_ff @(posedge CLK) begin
		if (!RST_B)
			tx_shift <= '0;
		else if (sclk_rise && last_bit)
			tx_shift <= SER_TX_WORD;
		else if (sclk_rise)
			tx_shift <= {tx_shift[SER_W-2:0], 1'b0};
	end

	// serial output changes on synced edge
	always_ff @(posedge CLK) begin
		if (!RST_B)
			DEV_SERIAL_OUT <= 1'b0;
		else if (sclk_rise && last_bit)
			DEV_SERIAL_OUT <= SER_TX_WORD[SER_W-1];
		else if (sclk_rise)
			DEV_SERIAL_OUT <= tx_shift[SER_W-2];
	end

	// =====================================================
	// halt control
	tdp_pkg::tdp_halt_e halt_st;

	// request waits for instruction end, resume leaves halt only once the request is released
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			halt_st <= tdp_pkg::HT_RUN;
		end else begin
			case (halt_st)
				tdp_pkg::HT_RUN: begin
					if (breakpoint_request_n_req && CORE_INSTR_DONE)
						halt_st <= tdp_pkg::HT_HALT;
					else if (breakpoint_request_n_req)
						halt_st <= tdp_pkg::HT_PEND;
				end
				tdp_pkg::HT_PEND: begin
					if (CORE_INSTR_DONE)
						halt_st <= tdp_pkg::HT_HALT;
				end
				tdp_pkg::HT_HALT: begin
					if (CORE_RESUME && !breakpoint_request_n_req)
						halt_st <= tdp_pkg::HT_RUN;
				end
				default: halt_st <= tdp_pkg::HT_RUN;
			endcase
		end
	end

	assign CORE_HALT = (halt_st == tdp_pkg::HT_HALT);

	// =====================================================
	// capture into trace store
	logic trace_off;
	logic [1:0] br_bytes;
	logic want_cap;
	tdp_pkg::tdp_entry_s cap_entry;
	tdp_pkg::tdp_entry_s head;
	logic [EW-1:0] head_raw;
	logic fifo_empty;
	logic fifo_full;
	logic fifo_pop;
	logic fifo_push;
	logic mark_slot;

	assign trace_off = DEBUG_CONFIG_STATUS[tdp_pkg::CFG_TRACE_DISABLE_BIT];
	assign br_bytes = DEBUG_CONFIG_STATUS[tdp_pkg::CFG_BRANCH_BYTES_LSB +: 2];

	// write-data always captured, branch targets by config
	always_comb begin
		want_cap = 1'b0;
		cap_entry.value = CORE_TRACE.value;
		cap_entry.bytes_m1 = CORE_TRACE.wdata_bytes_m1;
		if (CORE_TRACE.wdata) begin
			want_cap = 1'b1;
		end else if (CORE_TRACE.code == tdp_pkg::PST_BRANCH &&
			CORE_TRACE.branch_variant &&
			br_bytes != tdp_pkg::BRANCH_BYTES_OFF) begin
			want_cap = 1'b1;
			cap_entry.bytes_m1 = br_bytes;
		end
	end

	// stall only when both entries still wait, or status slot taken
	assign CORE_STALL = (want_cap && fifo_full) || mark_slot;
	assign fifo_push = want_cap && !fifo_full && !mark_slot;

	tdp_fifo #(
		.WIDTH(EW),
		.DEPTH(DEPTH)
	) u_store (
		.clk(CLK),
		.rst_b(RST_B),
		.push(fifo_push),
		.wdata(cap_entry),
		.pop(fifo_pop),
		.rdata(head_raw),
		.empty(fifo_empty),
		.full(fifo_full)
	);

	assign head = tdp_pkg::tdp_entry_s'(head_raw);

	// =====================================================
	// drain sequencer: marker then nibbles
	tdp_pkg::tdp_drain_e drain_st;
	logic [tdp_pkg::TRACE_W-1:0] out_shift;
	logic [2:0] nib_left;
	logic start_next;
	logic showing;

	assign start_next = !fifo_empty &&
		(drain_st == tdp_pkg::DR_IDLE ||
		(drain_st == tdp_pkg::DR_DATA && nib_left == 3'h0));
	assign mark_slot = start_next;
	assign fifo_pop = start_next;
	// marker cycle registers the first nibble, which reaches the pins one clock after the marker
	assign showing = (drain_st == tdp_pkg::DR_MARK) ||
		(drain_st == tdp_pkg::DR_DATA);

	// sequencer state
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			drain_st <= tdp_pkg::DR_IDLE;
		end else begin
			case (drain_st)
				tdp_pkg::DR_IDLE: begin
					if (start_next)
						drain_st <= tdp_pkg::DR_MARK;
				end
				tdp_pkg::DR_MARK: begin
					drain_st <= tdp_pkg::DR_DATA;
				end
				tdp_pkg::DR_DATA: begin
					if (start_next)
						drain_st <= tdp_pkg::DR_MARK;
					else if (nib_left == 3'h0)
						drain_st <= tdp_pkg::DR_IDLE;
				end
				default: drain_st <= tdp_pkg::DR_IDLE;
			endcase
		end
	end

	// nibble shifter, low nibble first; count excludes the marker nibble and the last nibble
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			out_shift <= '0;
			nib_left <= 3'h0;
		end else if (start_next) begin
			out_shift <= head.value;
			nib_left <= {head.bytes_m1, 1'b0};
		end else if (showing) begin
			out_shift <= {4'h0, out_shift[tdp_pkg::TRACE_W-1:4]};
			if (drain_st == tdp_pkg::DR_DATA && nib_left != 3'h0)
				nib_left <= nib_left - 3'h1;
		end
	end

	// =====================================================
	// status and data pins, registered each clock
	logic [3:0] next_pst;
	logic [3:0] next_dd;

	// trace off first, then halt, then marker, then continue on stall, then pipeline code
	always_comb begin
		next_pst = CORE_TRACE.code;
		if (CORE_HALT)
			next_pst = tdp_pkg::PST_HALTED;
		else if (start_next)
			next_pst = tdp_pkg::PST_MARK_BASE | {2'h0, head.bytes_m1};
		else if (CORE_STALL)
			next_pst = tdp_pkg::PST_CONTINUE;
		if (trace_off)
			next_pst = tdp_pkg::PST_CONTINUE;
	end

	// zero while trace is off, else captured nibble while draining, else breakpoint status
	always_comb begin
		next_dd = BREAKPOINT_STATUS;
		if (showing)
			next_dd = out_shift[3:0];
		if (trace_off)
			next_dd = tdp_pkg::NIBBLE_RESET;
	end

	// output flops on the rising edge
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			PROCESSOR_STATUS_CODE <= tdp_pkg::PST_CONTINUE;
			DEBUG_DATA_NIBBLE <= tdp_pkg::NIBBLE_RESET;
		end else begin
			PROCESSOR_STATUS_CODE <= next_pst;
			DEBUG_DATA_NIBBLE <= next_dd;
		end
	end

	// =====================================================
	// sample clock gate, enable moves while clock is low
	logic clk_gate;

	// falling edge enable keeps the gated clock glitch free
	always_ff @(negedge CLK) begin
		if (!RST_B)
			clk_gate <= 1'b0;
		else
			clk_gate <= !trace_off;
	end

	assign STATUS_SAMPLE_CLOCK = CLK & clk_gate;
endmodule

// File: tdp_assertions.sv
`timescale 1ns/1ps
// ==========================================
// pin level checker
module tdp_checker (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic BREAKPOINT_REQUEST_N,
	input wire logic DEV_SERIAL_CLOCK,
	input wire logic DEV_SERIAL_OUT,
	input wire logic [3:0] PROCESSOR_STATUS_CODE,
	input wire logic [3:0] DEBUG_DATA_NIBBLE,
	input wire logic [tdp_pkg::CFG_W-1:0] DEBUG_CONFIG_STATUS,
	input wire tdp_pkg::tdp_core_s CORE_TRACE,
	input wire logic CORE_INSTR_DONE,
	input wire logic CORE_RESUME,
	input wire logic CORE_STALL,
	input wire logic CORE_HALT,
	input wire logic SER_TX_LOAD,
	input wire logic SER_RX_VALID
);
	logic [5:0] sclk_hist;
	logic off;
	// serial clock pin history
	always_ff @(posedge CLK) begin
		sclk_hist <= {sclk_hist[4:0], DEV_SERIAL_CLOCK};
	end
	assign off = DEBUG_CONFIG_STATUS[tdp_pkg::CFG_TRACE_DISABLE_BIT];
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_B);
	// ==========================================
	// halt, status and serial relations
	AST_HALT_SHOWN: assert property ($past(CORE_HALT) && !$past(off)
		|-> PROCESSOR_STATUS_CODE == tdp_pkg::PST_HALTED)
		else $error("halt not shown on status");
	AST_HALT_CAUSE: assert property ($rose(CORE_HALT)
		|-> $past(CORE_INSTR_DONE) && !$past(BREAKPOINT_REQUEST_N, 2))
		else $error("halt without request and instruction end");
	AST_HALT_LEAVE: assert property ($fell(CORE_HALT) |-> $past(CORE_RESUME))
		else $error("halt left without resume");
	AST_PST_FOLLOW: assert property ($past(RST_B) && !$past(CORE_STALL)
		&& !$past(CORE_HALT) && !$past(off) && !PROCESSOR_STATUS_CODE[3]
		|-> PROCESSOR_STATUS_CODE == $past(CORE_TRACE.code))
		else $error("status does not follow pipeline");
	AST_STALL_ZERO: assert property ($past(RST_B) && $past(CORE_STALL)
		&& !$past(CORE_HALT) && !$past(off) && !PROCESSOR_STATUS_CODE[3]
		|-> PROCESSOR_STATUS_CODE == tdp_pkg::PST_CONTINUE)
		else $error("stall cycle not shown as continue");
	AST_TRACE_OFF: assert property ($past(off)
		|-> PROCESSOR_STATUS_CODE == 4'h0 && DEBUG_DATA_NIBBLE == 4'h0)
		else $error("trace outputs active while disabled");
	AST_MARK_ONE: assert property (PROCESSOR_STATUS_CODE[3:2] == 2'h2
		|=> PROCESSOR_STATUS_CODE[3:2] != 2'h2)
		else $error("byte marker longer than one cycle");
	AST_DSO_QUIET: assert property ((sclk_hist == 6'h00 || sclk_hist == 6'h3F)
		|-> $stable(DEV_SERIAL_OUT))
		else $error("serial output moved without clock rise");
	AST_LOAD_ANSWER: assert property (SER_TX_LOAD |=> SER_RX_VALID)
		else $error("word end without receive pulse");
	AST_RX_PULSE: assert property (SER_RX_VALID |=> (!SER_RX_VALID) [*4])
		else $error("receive pulse too long");
endmodule
bind tdp_top tdp_checker u_chk (.CLK(CLK), .RST_B(RST_B),
	.BREAKPOINT_REQUEST_N(BREAKPOINT_REQUEST_N),
	.DEV_SERIAL_CLOCK(DEV_SERIAL_CLOCK), .DEV_SERIAL_OUT(DEV_SERIAL_OUT),
	.PROCESSOR_STATUS_CODE(PROCESSOR_STATUS_CODE),
	.DEBUG_DATA_NIBBLE(DEBUG_DATA_NIBBLE),
	.DEBUG_CONFIG_STATUS(DEBUG_CONFIG_STATUS), .CORE_TRACE(CORE_TRACE),
	.CORE_INSTR_DONE(CORE_INSTR_DONE), .CORE_RESUME(CORE_RESUME),
	.CORE_STALL(CORE_STALL), .CORE_HALT(CORE_HALT),
	.SER_TX_LOAD(SER_TX_LOAD), .SER_RX_VALID(SER_RX_VALID));

// File: tdp_dev_model.sv
`timescale 1ns/1ps
// ==========================================
// development system serial side
module tdp_dev_model #(
	parameter int W = tdp_pkg::SERIAL_W
) (
	input wire logic link_clk,
	input wire logic go,
	input wire logic [W-1:0] tx_word,
	input wire logic dev_serial_out,
	output logic sclk,
	output logic sdin,
	output logic busy,
	output logic [W-1:0] rx_word
);
	int i;
	// one frame per go, clock still between frames
	initial begin
		sclk = 1'b0;
		sdin = 1'b0;
		busy = 1'b0;
		rx_word = '0;
		forever begin
			@(posedge link_clk);
			if (go) begin
				busy = 1'b1;
				for (i = W - 1; i >= 0; i--) begin
					sdin = tx_word[i]; // msb first
					repeat (2) @(posedge link_clk);
					rx_word = {rx_word[W-2:0], dev_serial_out}; // bit before rise
					sclk = 1'b1; // 36 ns period, under fifth of core rate
					repeat (3) @(posedge link_clk);
					sclk = 1'b0;
					@(posedge link_clk);
				end
				sdin = ~sdin; // idle data line not left at last bit
				busy = 1'b0;
			end
		end
	end
endmodule

// File: testbench.sv
`timescale 1ns/1ps
// ==========================================
// self-checking bench for the debug pins
module testbench;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_b = 1'b0;
	logic breakpoint_request_n_n = 1'b1;
	logic [31:0] cfg = 32'h0;
	logic [3:0] bp_stat = 4'h6;
	tdp_pkg::tdp_core_s trace = '0;
	logic done = 1'b0;
	logic resume = 1'b0;
	logic go = 1'b0;
	logic [16:0] tx_word = 17'h0;
	logic dev_serial_out, sclk, sdin, sstb, stall, halt, tx_load, rx_valid, busy;
	logic [3:0] processor_status_code, debug_data_nibble;
	logic [16:0] rx_word, far_word;
	logic [16:0] far_tx = 17'h0;
	int error_cnt = 0;
	int checked = 0;
	int strb_cnt = 0;
	int rxv_cnt = 0;
	always #2.5 clk = ~clk;
	initial #1.3 forever #3 link_clk = ~link_clk;
	always @(posedge sstb) strb_cnt <= strb_cnt + 1;
	always @(posedge clk) if (rx_valid === 1'b1) rxv_cnt <= rxv_cnt + 1;
	// ==========================================
	// design under test and far side serial model
	tdp_top u_dut (.CLK(clk), .RST_B(rst_b), .BREAKPOINT_REQUEST_N(breakpoint_request_n_n),
		.DEV_SERIAL_CLOCK(sclk), .DEV_SERIAL_IN(sdin), .DEV_SERIAL_OUT(dev_serial_out),
		.PROCESSOR_STATUS_CODE(processor_status_code), .DEBUG_DATA_NIBBLE(debug_data_nibble),
		.STATUS_SAMPLE_CLOCK(sstb), .DEBUG_CONFIG_STATUS(cfg),
		.BREAKPOINT_STATUS(bp_stat), .CORE_TRACE(trace),
		.CORE_INSTR_DONE(done), .CORE_RESUME(resume), .CORE_STALL(stall),
		.CORE_HALT(halt), .SER_TX_WORD(tx_word), .SER_TX_LOAD(tx_load),
		.SER_RX_WORD(rx_word), .SER_RX_VALID(rx_valid));
	tdp_dev_model u_far (.link_clk(link_clk), .go(go), .tx_word(far_tx),
		.dev_serial_out(dev_serial_out), .sclk(sclk), .sdin(sdin), .busy(busy), .rx_word(far_word));
	// ==========================================
	// shared tasks
	task check(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	task final_report;
		if (error_cnt == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task step;
		@(posedge clk);
		#1;
	endtask
	task push(input tdp_pkg::tdp_core_s t, output int stalls);
		logic s;
		stalls = 0;
		step;
		trace = t;
		repeat (40) begin
			@(negedge clk);
			s = stall;
			step;
			if (s !== 1'b1) break;
			stalls++;
		end
		trace = '0;
	endtask
	task drain_check(input logic [3:0] mark, input logic [31:0] v, input int n);
		int i;
		i = 0;
		while (i < 12 && processor_status_code !== mark) begin
			@(negedge clk);
			i++;
		end
		check(processor_status_code === mark, "byte marker");
		for (i = 0; i < n; i++) begin
			@(negedge clk);
			check(debug_data_nibble === v[4*i+:4], "data nibble");
		end
		@(negedge clk);
		check(debug_data_nibble === bp_stat, "breakpoint status nibble");
	endtask
	task frame;
		int i;
		go = 1'b1;
		for (i = 0; i < 50 && busy !== 1'b1; i++) step;
		go = 1'b0;
		for (i = 0; i < 2000 && busy === 1'b1; i++) step;
		repeat (8) step;
	endtask
	// ==========================================
	// scenarios
	task t_codes;
		logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h7};
		foreach (codes[k]) begin
			step;
			trace.code = codes[k];
			repeat (2) @(negedge clk);
			check(processor_status_code === codes[k], "pipeline code");
		end
		step;
		trace = '0;
	endtask
	task t_trace;
		int s;
		logic [1:0] b;
		for (int k = 0; k < 4; k++) begin
			b = k[1:0];
			push({tdp_pkg::PST_PULSE_WDATA, 1'b0, 1'b1, b, 32'h87654321}, s);
			check(s == 0, "stall with empty store");
			drain_check(tdp_pkg::PST_MARK_BASE + 4'(b), 32'h87654321, 2 * k + 2);
		end
		step;
		cfg[9:8] = 2'h3;
		push({tdp_pkg::PST_BRANCH, 1'b1, 1'b0, 2'h0, 32'hFEDCBA98}, s);
		drain_check(4'hB, 32'hFEDCBA98, 8);
		step;
		cfg[9:8] = 2'h0;
	endtask
	task t_stall;
		int s1, s4, s;
		push({tdp_pkg::PST_PULSE_WDATA, 1'b0, 1'b1, 2'h3, 32'h11111111}, s1);
		push({tdp_pkg::PST_PULSE_WDATA, 1'b0, 1'b1, 2'h3, 32'h22222222}, s);
		push({tdp_pkg::PST_PULSE_WDATA, 1'b0, 1'b1, 2'h3, 32'h33333333}, s);
		push({tdp_pkg::PST_PULSE_WDATA, 1'b0, 1'b1, 2'h3, 32'h44444444}, s4);
		check(s1 == 0 && s4 > 0, "stall on full store");
		repeat (40) step;
	endtask
	task t_halt;
		int i;
		breakpoint_request_n_n = 1'b0;
		repeat (3) step;
		done = 1'b1;
		step;
		done = 1'b0;
		for (i = 0; i < 8 && processor_status_code !== tdp_pkg::PST_HALTED; i++) @(negedge clk);
		check(processor_status_code === tdp_pkg::PST_HALTED && halt === 1'b1, "halt");
		repeat (5) @(negedge clk);
		check(processor_status_code === tdp_pkg::PST_HALTED, "halt held");
		step;
		breakpoint_request_n_n = 1'b1;
		repeat (3) step;
		resume = 1'b1;
		step;
		resume = 1'b0;
		repeat (3) @(negedge clk);
		check(halt === 1'b0 && processor_status_code === 4'h0, "resume");
	endtask
	task t_disable;
		int c;
		step;
		cfg[tdp_pkg::CFG_TRACE_DISABLE_BIT] = 1'b1;
		repeat (3) step;
		c = strb_cnt;
		repeat (8) step;
		check(strb_cnt == c && sstb === 1'b0, "sample clock off");
		check(processor_status_code === 4'h0 && debug_data_nibble === 4'h0, "trace off");
		cfg[tdp_pkg::CFG_TRACE_DISABLE_BIT] = 1'b0;
		repeat (3) step;
		c = strb_cnt;
		repeat (8) step;
		check(strb_cnt == c + 8, "sample clock runs");
	endtask
	task t_serial;
		int c;
		c = rxv_cnt;
		tx_word = 17'h1A5C3;
		send_word(17'h0B4E7);
		check(rx_word === 17'h0B4E7 && rxv_cnt == c + 1, "rx word");
		send_word(17'h15A3C);
		check(rx_word === 17'h15A3C, "rx word two");
		check(far_word === 17'h1A5C3, "serial response");
	endtask
	task send_word(input logic [16:0] w);
		far_tx = w;
		frame;
	endtask
	// ==========================================
	// main sequence and watchdog
	initial begin
		repeat (16) @(posedge clk);
		#1;
		rst_b = 1'b1;
		repeat (2) step;
		t_codes;
		t_trace;
		t_stall;
		t_halt;
		t_disable;
		t_serial;
		final_report;
	end
	initial begin
		#60000;
		error_cnt++;
		final_report;
	end
endmodule
